// *** logic/wdt_pkg.sv ***
// package for the watchdog reset timer: register map, fields, timing
// assumes a 200 MHz core clock driving the counters
package wdt_pkg;
    localparam logic [7:0] WDT_CTRL_ADDR  = 8'hc0;
    localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
    localparam int WDT_ENABLE_BIT   = 0;
    localparam int WDT_STATUS_BIT   = 1;
    localparam int WDT_REF2_BIT     = 2;
    localparam int WDT_REF1_BIT     = 3;
    localparam int WDT_UNUSED_BIT   = 4;
    localparam int WDT_PRE_LSB      = 5;
    localparam int WDT_PRE_W        = 3;
    localparam int WDT_CNT_W        = 16;
    localparam int WDT_CLK_MHZ      = 200;
    localparam int WDT_BASE_MS      = 16;
    localparam int WDT_BASE_TICKS   = 65536;
    // cycles per counter tick so that 2^16 ticks span the base period
    localparam int WDT_TICK_CYCLES  =
        (WDT_BASE_MS * WDT_CLK_MHZ * 1000) / WDT_BASE_TICKS;
    localparam int WDT_RST_PULSE_CYCLES = 16;
    typedef enum logic [1:0] {
        WDT_REF_IDLE  = 2'b00,
        WDT_REF_ARMED = 2'b01
    } wdt_ref_e;
endpackage

// *** logic/wdt_prescaler.sv ***
// tick generator: one pulse every (ratio << shift) clock cycles
// assumes clear held by the owner while the watchdog is off
`timescale 1ns/10ps
module wdt_prescaler
    import wdt_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic [2:0] shift,
    output logic            tick
);
    localparam int PW = 32;
    logic [PW-1:0] cnt_q;
    logic [PW-1:0] limit;

    assign limit = PW'(TICK_CYCLES) << shift;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clear || cnt_q >= limit - PW'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + PW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= !clear && (cnt_q >= limit - PW'(1));
        end
    end
endmodule

// *** logic/wdt_timer.sv ***
// watchdog reset timer with its bit-addressable control register
// assumes core-side sfr strobes on clk; ext_rst from a pin is synchronised
`timescale 1ns/10ps
module wdt_timer
    import wdt_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES,
    parameter int CNT_W       = WDT_CNT_W
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ext_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_bit_wr,
    input  wire logic [2:0] sfr_bit_sel,
    input  wire logic       sfr_bit_val,
    output logic [7:0]      sfr_rdata,
    output logic            sys_reset
);
    logic             ext_s1_q;
    logic             ext_s2_q;
    logic             hit;
    logic [7:0]       ctrl_q;
    logic [7:0]       wr_val;
    logic             wr_en;
    logic [CNT_W-1:0] cnt_q;
    logic             tick;
    logic             timeout;
    logic             refresh_ok;
    logic             status_q;
    logic [4:0]       rst_cnt_q;
    wdt_ref_e         ref_q;
    logic             enable;
    logic [2:0]       pre_sel;
    logic             ref1_set;
    logic             ref2_set;
    logic             ref_start;
    logic             wr_byte;
    logic             wr_bit;
    logic             cnt_clear;
    logic             rst_busy;
    logic [7:0]       rd_word;

    // external reset pin synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_rst;
            ext_s2_q <= ext_s1_q;
        end
    end

    assign hit     = (sfr_addr == WDT_CTRL_ADDR);
    assign wr_byte = hit && sfr_wr;
    assign wr_bit  = hit && sfr_bit_wr;
    assign wr_en   = wr_byte || wr_bit;

    // named fields of the stored control byte
    assign enable   = ctrl_q[WDT_ENABLE_BIT];
    assign pre_sel  = ctrl_q[WDT_PRE_LSB +: WDT_PRE_W];
    assign ref1_set = ctrl_q[WDT_REF1_BIT];
    assign ref2_set = ctrl_q[WDT_REF2_BIT];

    // byte write or single-bit read-modify-write; byte write wins
    always_comb begin
        wr_val = ctrl_q;
        if (wr_byte) begin
            wr_val = sfr_wdata;
        end else if (wr_bit) begin
            wr_val[sfr_bit_sel] = sfr_bit_val;
        end
    end

    // first half of a refresh: bit 3 newly set, bit 2 left clear
    assign ref_start = wr_val[WDT_REF1_BIT] && !ref1_set
                       && !wr_val[WDT_REF2_BIT];

    // second half: bit 2 newly set while bit 3 is still held
    assign refresh_ok = wr_en && ref_q == WDT_REF_ARMED
                        && wr_val[WDT_REF1_BIT]
                        && wr_val[WDT_REF2_BIT]
                        && !ref2_set;

    // counter wrap and tick coincide; enable drops on this edge
    assign timeout = enable && tick
                     && (&cnt_q);

    // counters held clear while off or on a refresh
    assign cnt_clear = !enable || refresh_ok;

    // control bits; status lives apart so it can outlive the watchdog reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= WDT_CTRL_RESET;
        end else if (ext_s2_q || timeout) begin
            ctrl_q <= WDT_CTRL_RESET;
        end else if (refresh_ok) begin
            ctrl_q <= wr_val;
            ctrl_q[WDT_REF1_BIT] <= 1'b0;
            ctrl_q[WDT_REF2_BIT] <= 1'b0;
            ctrl_q[WDT_UNUSED_BIT] <= 1'b0;
            ctrl_q[WDT_STATUS_BIT] <= 1'b0;
        end else if (wr_en) begin
            ctrl_q <= wr_val;
            ctrl_q[WDT_UNUSED_BIT] <= 1'b0;
            ctrl_q[WDT_STATUS_BIT] <= 1'b0;
        end
    end

    // refresh sequence tracker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_q <= WDT_REF_IDLE;
        end else if (ext_s2_q || timeout || refresh_ok) begin
            ref_q <= WDT_REF_IDLE;
        end else if (wr_en) begin
            case (ref_q)
                WDT_REF_IDLE: begin
                    if (ref_start) begin
                        ref_q <= WDT_REF_ARMED;
                    end
                end
                WDT_REF_ARMED: begin
                    if (!wr_val[WDT_REF1_BIT]) begin
                        ref_q <= WDT_REF_IDLE;
                    end
                end
                default: ref_q <= WDT_REF_IDLE;
            endcase
        end
    end

    // status: set by timeout wins, cleared only by power-on or ext reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= 1'b0;
        end else if (timeout) begin
            status_q <= 1'b1;
        end else if (ext_s2_q) begin
            status_q <= 1'b0;
        end
    end

    wdt_prescaler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_prescaler (
        .clk   (clk),
        .rst   (rst),
        .clear (cnt_clear),
        .shift (pre_sel),
        .tick  (tick)
    );

    // sixteen-bit timeout counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (cnt_clear) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // stretched system reset pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt_q <= '0;
        end else if (timeout) begin
            rst_cnt_q <= 5'(WDT_RST_PULSE_CYCLES);
        end else if (rst_cnt_q != 5'h00) begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
        end
    end

    assign rst_busy = (rst_cnt_q > 5'h01);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= timeout || rst_busy;
        end
    end

    // read view: status from its own flop, unused bit forced low
    always_comb begin
        rd_word                           = 8'h00;
        rd_word[WDT_PRE_LSB +: WDT_PRE_W] = pre_sel;
        rd_word[WDT_UNUSED_BIT]           = 1'b0;
        rd_word[WDT_REF1_BIT]             = ref1_set;
        rd_word[WDT_REF2_BIT]             = ref2_set;
        rd_word[WDT_STATUS_BIT]           = status_q;
        rd_word[WDT_ENABLE_BIT]           = enable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (hit) begin
            sfr_rdata <= rd_word;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end
endmodule

// *** tb/watchdog_reset_timer_tb_top.sv ***
// bench for the watchdog timer, counts shortened
// assumes wdt_chk bound in its own file
`timescale 1ns/10ps
module watchdog_reset_timer_tb_top
    import wdt_pkg::*;
;
    logic       clk, rst, ext_rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sys_reset;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_sel;
    int         fails, checks_done, n;
    always #2.5 clk = ~clk;
    wdt_timer #(.TICK_CYCLES(1), .CNT_W(4)) wdt_timer_i (.clk(clk),
        .rst(rst), .ext_rst(ext_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
        .sfr_rdata(sfr_rdata), .sys_reset(sys_reset));
    task automatic complete_run;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        repeat (2) @(negedge clk);
        cmp(sfr_rdata, exp);
    endtask
    task automatic ww(input logic [7:0] d);
        @(negedge clk);
        {sfr_wr, sfr_wdata} = {1'b1, d};
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic bw(input logic [2:0] b, input logic v);
        @(negedge clk);
        {sfr_bit_wr, sfr_bit_sel, sfr_bit_val} = {1'b1, b, v};
        @(negedge clk);
        sfr_bit_wr = 1'b0;
    endtask
    task automatic refresh;
        bw(3'h3, 1'b1);
        bw(3'h2, 1'b1);
    endtask
    task automatic wait_rst(input int lo, input int hi);
        n = 0;
        while (sys_reset !== 1'b1 && n < hi) begin
            @(negedge clk);
            n++;
        end
        cmp(8'(n >= lo && n < hi), 8'h01);
        if (n >= hi) complete_run();
        repeat (20) @(negedge clk);
    endtask
    task automatic s_reset;
        rd(8'h00);
        ww(8'hff);
        rd(8'hed);
        ww(8'h00);
        sfr_addr = 8'h80;
        rd(8'h00);
        sfr_addr = WDT_CTRL_ADDR;
    endtask
    task automatic s_disable;
        bw(3'h0, 1'b1);
        repeat (10) @(negedge clk);
        bw(3'h0, 1'b0);
        repeat (40) @(negedge clk);
        rd(8'h00);
        bw(3'h0, 1'b1);
        wait_rst(12, 24);
    endtask
    task automatic s_period;
        for (int p = 0; p < 8; p++) begin
            ww({3'(p), 5'h00});
            bw(3'h0, 1'b1);
            wait_rst((16 << p) - 4, (16 << p) + 6);
            rd(8'h02);
        end
    endtask
    task automatic s_refresh;
        bw(3'h0, 1'b1);
        repeat (6) begin
            repeat (8) @(negedge clk);
            refresh();
        end
        rd(8'h03);
        bw(3'h2, 1'b1);
        bw(3'h3, 1'b1);
        wait_rst(8, 24);
    endtask
    task automatic s_ext;
        ext_rst = 1'b1;
        repeat (6) @(negedge clk);
        ext_rst = 1'b0;
        rd(8'h00);
    endtask
    initial begin
        {clk, rst, ext_rst, sfr_wr, sfr_bit_wr, sfr_bit_val} = 6'b010000;
        {sfr_addr, sfr_wdata, sfr_bit_sel} = {WDT_CTRL_ADDR, 8'h00, 3'h0};
        {fails, checks_done} = {32'd0, 32'd0};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        s_reset();
        s_disable();
        s_period();
        s_refresh();
        s_ext();
        complete_run();
    end
endmodule

// *** tb/wdt_chk.sv ***
// port checker for the watchdog timer
// assumes control register address held at 0xc0 by the driver
`timescale 1ns/10ps
module wdt_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ext_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic       sfr_bit_val,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sys_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_set(int b);
        sfr_bit_wr && sfr_bit_sel == b && sfr_bit_val && sfr_addr == 8'hc0;
    endsequence
    sequence s_refresh;
        s_set(3) ##2 s_set(2);
    endsequence
    chk_pulse_hold:
    assert property ($rose(sys_reset) |-> sys_reset[*8]) else $error("short");
    chk_only_enabled:
    assert property ($rose(sys_reset) |-> $past(sfr_rdata[0]))
        else $error("reset while off");
    chk_status_set:
    assert property ($rose(sys_reset) |-> ##1 sfr_rdata[1])
        else $error("status not set");
    chk_unused_zero:
    assert property (sfr_rdata[4] == 1'b0) else $error("bit4 set");
    chk_refresh_clears:
    assert property (s_refresh |-> ##2 sfr_rdata[3:2] == 2'b00)
        else $error("refresh bits kept");
    chk_no_early_reset:
    assert property (s_refresh |-> (!$rose(sys_reset))[*8])
        else $error("reset after refresh");
    chk_period_store:
    assert property (sfr_wr && sfr_addr == 8'hc0 && !sys_reset |->
        ##2 sfr_rdata[7:5] == $past(sfr_wdata[7:5], 2)) else $error("pre");
    chk_ext_clear:
    assert property (ext_rst[*5] |-> sfr_rdata == 8'h00)
        else $error("ext clear");
endmodule
bind wdt_timer wdt_chk wdt_chk_i (.clk(clk), .rst(rst), .ext_rst(ext_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .sys_reset(sys_reset));
